/* design/mlsc_pkg.sv */
// mlsc_pkg: shared constants and carrier types for the mission logging and
// scratchpad control block; assumes byte-wide memory ports.
package mlsc_pkg;
    // datalog and scratchpad capacity and geometry
    localparam int LOG_BYTES = 8192;
    localparam int LOG_ENTRIES_8 = 8192;
    localparam int LOG_ENTRIES_16 = 4096;
    localparam int LOG_AW = 13;
    localparam int SP_BYTES = 32;
    localparam int SP_AW = 5;
    // scratchpad transfer status layout
    localparam logic [4:0] SP_LAST_OFS = 5'h1f;
    localparam int ES_PF_BIT = 5;
    localparam int ES_ZERO_BIT = 6;
    localparam int ES_AA_BIT = 7;
    // password window in the device address map
    localparam logic [15:0] PW_LO_ADDR = 16'h0228;
    localparam logic [15:0] PW_HI_ADDR = 16'h0237;
    // timing: a second tick and a minute as seconds
    localparam int CLK_HZ = 100_000_000;
    localparam int SEC_NS = 1_000_000_000;
    localparam int CLK_NS = 10;
    localparam int SEC_CYC = SEC_NS / CLK_NS;
    localparam logic [5:0] MIN_SECS = 6'h3c;
    localparam logic [13:0] RATE_ONE = 14'h0001;
    localparam logic [23:0] CNT_ONE = 24'h000001;

    typedef enum logic [1:0] {
        CMD_NONE,
        CMD_WRITE_SP,
        CMD_COPY_SP,
        CMD_START
    } mlsc_cmd_e;

    // mission configuration as held in the control bytes
    typedef struct packed {
        logic wrap_enable;
        logic high_speed_sampling;
        logic start_on_alarm;
        logic logging_enable;
        logic entry16;
        logic [13:0] sample_rate;
        logic [15:0] start_delay;
    } mlsc_cfg_s;

    // one byte toward the datalog or general memory
    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [7:0] data;
    } mlsc_mem_s;
endpackage

/* design/mlsc_spad_mem.sv */
// mlsc_spad_mem: 32-byte scratchpad storage with a registered read port.
// assumes one write and one read address per clock.
`timescale 1ns/10ps
module mlsc_spad_mem (
    // clock only, no reset
    input wire logic clk_i,
    // write port
    input wire logic we_i,
    input wire logic [4:0] waddr_i,
    input wire logic [7:0] wdata_i,
    // read port
    input wire logic [4:0] raddr_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem_q [mlsc_pkg::SP_BYTES];

    // storage and registered read, no reset needed for data
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
        rdata_o <= mem_q[raddr_i];
    end
endmodule // mlsc_spad_mem

/* design/mlsc_top.sv */
// mlsc_top: mission sequencing, datalog addressing and scratchpad status.
// assumes the serial front end decodes commands into one-cycle strobes and
// that the sampling engine flags each finished measurement.
// Summary of operation
// - datalog holds 8192 byte entries or 4096 two-byte entries
// - 16-bit entries put high byte at lower address, low byte next
// - on full, stop logging or wrap to datalog start, entry by entry
// - wrap_enable one means overwrite; zero means stop when full
// - enabled alarm that has fired makes device answer conditional search
// - high_speed_sampling counts interval in seconds, else minutes
// - start command with logging_enable sets mission_active and clears memory_cleared
// - normal start: wait delay, stamp time, log, bump both counters
// - alarm start: after delay, samples bump device counter only
// - alarm start: stamp at alarm, first log one period later
// - general memory writable and all memory readable during mission
// - password locations read back as zero bytes
// - end_status read-only; low five bits hold ending offset
// - copy happens only when ending offset equals 1Fh
// - partial_byte_flag bit 5 on odd bit count; bit 6 reads zero
// - target low five bits give scratchpad start offset; full at 1Fh
// - authorization_accepted set on valid copy, cleared by scratch write
// - copy follows target low, high, end_status; then copy to target
// - regular speed by default; overdrive only when explicitly selected
// - logging engine memory access beats host access during mission
`timescale 1ns/10ps
module mlsc_top (
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RESETN_I,
    // decoded host commands
    input wire logic CMD_STROBE_I,
    input wire mlsc_pkg::mlsc_cmd_e CMD_I,
    input wire logic [15:0] TARGET_ADDR_I,
    input wire logic SP_BYTE_VALID_I,
    input wire logic [7:0] SP_BYTE_I,
    input wire logic SP_PARTIAL_I,
    input wire logic [23:0] COPY_AUTH_I,
    input wire logic CLEAR_I,
    input wire logic STOP_I,
    input wire logic OVERDRIVE_SET_I,
    input wire logic BUS_RESET_I,
    // host read port
    input wire logic HOST_RD_I,
    input wire logic [15:0] HOST_RD_ADDR_I,
    input wire logic [7:0] MEM_RDATA_I,
    // mission configuration and sampling engine
    input wire mlsc_pkg::mlsc_cfg_s CFG_I,
    input wire logic ALARM_EN_I,
    input wire logic SAMPLE_DONE_I,
    input wire logic SAMPLE_ALARM_I,
    input wire logic [15:0] SAMPLE_I,
    // host visible state
    output logic [7:0] TARGET_ADDR_LOW_O,
    output logic [7:0] TARGET_ADDR_HIGH_O,
    output logic [7:0] END_STATUS_O,
    output logic [7:0] HOST_RDATA_O,
    output logic MISSION_ACTIVE_O,
    output logic MEMORY_CLEARED_O,
    output logic STAMP_STROBE_O,
    output logic SAMPLE_REQ_O,
    output logic SEARCH_RESPOND_O,
    output logic OVERDRIVE_SELECT_O,
    output logic HOST_BLOCKED_O,
    output logic [23:0] MISSION_COUNT_O,
    output logic [23:0] DEVICE_COUNT_O,
    // memory write port
    output mlsc_pkg::mlsc_mem_s MEM_O
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_DELAY, ST_ARMED, ST_PRELOG, ST_LOG, ST_FULL
    } mlsc_mis_e;
    localparam int LOG_AW_W = mlsc_pkg::LOG_AW;

    // scratchpad state
    logic [7:0] ta_lo_q, ta_lo_d, ta_hi_q, ta_hi_d;
    logic [4:0] ofs_q, ofs_d, eofs_q, eofs_d;
    logic pf_q, pf_d, aa_q, aa_d;
    logic copy_q, copy_d;
    logic [4:0] cp_ofs_q, cp_ofs_d;
    logic [15:0] cp_addr_q, cp_addr_d;
    logic [7:0] sp_rdata;
    logic sp_we;
    logic [4:0] sp_raddr;
    // mission state
    mlsc_mis_e st_q, st_d;
    logic mip_q, mip_d, mclr_q, mclr_d, od_q, od_d, alarm_q, alarm_d;
    logic [26:0] sec_cnt_q, sec_cnt_d;
    logic [5:0] min_cnt_q, min_cnt_d;
    logic [15:0] dly_q, dly_d;
    logic [13:0] rate_q, rate_d;
    logic [23:0] mcnt_q, mcnt_d, dcnt_q, dcnt_d;
    logic req_q, req_d, stamp_q, stamp_d;
    logic lo_pend_q, lo_pend_d;
    logic [7:0] lo_byte_q, lo_byte_d;
    logic [LOG_AW_W-1:0] lo_addr_q, lo_addr_d;
    mlsc_pkg::mlsc_mem_s mem_q, mem_d;
    logic [7:0] rd_q, rd_d;
    logic sec_tick, min_tick, unit_tick, interval_end;
    logic [15:0] log_addr;
    logic log_full;

    mlsc_spad_mem u_spad (
        .clk_i(CLK_SYS_I),
        .we_i(sp_we),
        .waddr_i(ofs_q),
        .wdata_i(SP_BYTE_I),
        .raddr_i(sp_raddr),
        .rdata_o(sp_rdata)
    );

    assign sp_we = SP_BYTE_VALID_I;
    assign sp_raddr = copy_d ? cp_ofs_d : HOST_RD_ADDR_I[4:0];

    // scratchpad address, status and copy sequencing
    always_comb begin
        ta_lo_d = ta_lo_q;
        ta_hi_d = ta_hi_q;
        ofs_d = ofs_q;
        eofs_d = eofs_q;
        pf_d = pf_q;
        aa_d = aa_q;
        copy_d = copy_q;
        cp_ofs_d = cp_ofs_q;
        cp_addr_d = cp_addr_q;
        if (CMD_STROBE_I && CMD_I == mlsc_pkg::CMD_WRITE_SP) begin
            ta_lo_d = TARGET_ADDR_I[7:0];
            ta_hi_d = TARGET_ADDR_I[15:8];
            ofs_d = TARGET_ADDR_I[4:0];
            eofs_d = TARGET_ADDR_I[4:0];
            pf_d = 1'b0;
            aa_d = 1'b0;
        end
        if (SP_BYTE_VALID_I) begin
            eofs_d = ofs_q;
            aa_d = 1'b0;
            if (ofs_q != mlsc_pkg::SP_LAST_OFS) begin
                ofs_d = ofs_q + 5'h01; // full once 1Fh written
            end
        end
        if (SP_PARTIAL_I) begin
            pf_d = 1'b1;
        end
        // authorization must echo target low, high, end_status
        if (CMD_STROBE_I && CMD_I == mlsc_pkg::CMD_COPY_SP &&
            COPY_AUTH_I == {ta_lo_q, ta_hi_q, END_STATUS_O} &&
            eofs_q == mlsc_pkg::SP_LAST_OFS && !pf_q) begin
            copy_d = 1'b1;
            aa_d = 1'b1;
            cp_ofs_d = ta_lo_q[4:0];
            cp_addr_d = {ta_hi_q, ta_lo_q};
        end
        if (copy_q && !lo_pend_q && !(mip_q && SAMPLE_DONE_I)) begin
            cp_addr_d = cp_addr_q + 16'h0001;
            cp_ofs_d = cp_ofs_q + 5'h01;
            if (cp_ofs_q == eofs_q) begin
                copy_d = 1'b0;
            end
        end
    end

    // one tick per second, minute tick every sixty seconds
    assign sec_tick = sec_cnt_q == 27'(mlsc_pkg::SEC_CYC - 1);
    assign min_tick = sec_tick && min_cnt_q == mlsc_pkg::MIN_SECS - 6'h01;
    assign unit_tick = CFG_I.high_speed_sampling ? sec_tick : min_tick;
    assign interval_end = unit_tick && rate_q <= mlsc_pkg::RATE_ONE;

    // address from count and width, modulo capacity when wrapping
    always_comb begin
        log_full = CFG_I.entry16 ?
            mcnt_q >= 24'(mlsc_pkg::LOG_ENTRIES_16 - 1) :
            mcnt_q >= 24'(mlsc_pkg::LOG_ENTRIES_8 - 1);
        if (CFG_I.entry16) begin
            log_addr = {3'h0, mcnt_q[11:0], 1'b0};
        end else begin
            log_addr = {3'h0, mcnt_q[12:0]};
        end
    end

    // mission sequencer
    always_comb begin
        st_d = st_q;
        mip_d = mip_q;
        mclr_d = mclr_q;
        od_d = od_q;
        alarm_d = alarm_q;
        sec_cnt_d = sec_tick ? 27'h0 : sec_cnt_q + 27'h1;
        min_cnt_d = min_cnt_q;
        if (sec_tick) begin
            min_cnt_d = min_tick ? 6'h00 : min_cnt_q + 6'h01;
        end
        dly_d = dly_q;
        rate_d = rate_q;
        mcnt_d = mcnt_q;
        dcnt_d = dcnt_q;
        req_d = 1'b0;
        stamp_d = 1'b0;
        lo_pend_d = lo_pend_q;
        lo_byte_d = lo_byte_q;
        lo_addr_d = lo_addr_q;
        mem_d = '0;
        if (OVERDRIVE_SET_I) begin
            od_d = 1'b1;
        end else if (BUS_RESET_I) begin
            od_d = 1'b0;
        end
        if (unit_tick && st_q != ST_IDLE) begin
            rate_d = interval_end ? CFG_I.sample_rate : rate_q - 14'h0001;
        end
        if (SAMPLE_DONE_I && ALARM_EN_I && SAMPLE_ALARM_I) begin
            alarm_d = 1'b1;
        end
        case (st_q)
            ST_IDLE: begin
                if (CMD_STROBE_I && CMD_I == mlsc_pkg::CMD_START &&
                    CFG_I.logging_enable) begin
                    mip_d = 1'b1;
                    mclr_d = 1'b0;
                    dly_d = CFG_I.start_delay;
                    rate_d = CFG_I.sample_rate;
                    min_cnt_d = 6'h00;
                    st_d = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (dly_q == 16'h0000 || (min_tick && dly_q == 16'h0001)) begin
                    rate_d = CFG_I.sample_rate;
                    req_d = 1'b1;
                    stamp_d = !CFG_I.start_on_alarm;
                    st_d = CFG_I.start_on_alarm ? ST_ARMED : ST_LOG;
                end else if (min_tick) begin
                    dly_d = dly_q - 16'h0001;
                end
            end
            ST_ARMED: begin
                if (interval_end) begin
                    req_d = 1'b1;
                end
                if (SAMPLE_DONE_I) begin
                    dcnt_d = dcnt_q + mlsc_pkg::CNT_ONE;
                    if (SAMPLE_ALARM_I) begin
                        stamp_d = 1'b1;
                        st_d = ST_PRELOG;
                    end
                end
            end
            ST_PRELOG: begin
                if (interval_end) begin
                    req_d = 1'b1; // first log one period later
                    st_d = ST_LOG;
                end
            end
            ST_LOG: begin
                if (interval_end) begin
                    req_d = 1'b1;
                end
                if (SAMPLE_DONE_I) begin
                    mcnt_d = mcnt_q + mlsc_pkg::CNT_ONE;
                    dcnt_d = dcnt_q + mlsc_pkg::CNT_ONE;
                    mem_d.we = 1'b1; // engine beats host copy
                    mem_d.addr = log_addr;
                    mem_d.data = CFG_I.entry16 ? SAMPLE_I[15:8] : SAMPLE_I[7:0];
                    lo_pend_d = CFG_I.entry16;
                    lo_byte_d = SAMPLE_I[7:0];
                    lo_addr_d = LOG_AW_W'(log_addr + 16'h0001);
                    if (!CFG_I.wrap_enable && log_full) begin
                        st_d = ST_FULL;
                    end
                end
            end
            ST_FULL: begin
            end
            default: st_d = ST_IDLE;
        endcase
        if (lo_pend_q) begin
            lo_pend_d = 1'b0;
            mem_d.we = 1'b1;
            mem_d.addr = {3'h0, lo_addr_q}; // low byte at next address
            mem_d.data = lo_byte_q;
        end else if (copy_q && !(mip_q && SAMPLE_DONE_I)) begin
            mem_d.we = 1'b1; // general memory writable in mission
            mem_d.addr = cp_addr_q;
            mem_d.data = sp_rdata;
        end
        if (STOP_I && mip_q) begin
            mip_d = 1'b0;
            st_d = ST_IDLE;
        end
        if (CLEAR_I && !mip_q) begin
            mcnt_d = 24'h0;
            alarm_d = 1'b0;
            mclr_d = 1'b1;
        end
    end

    // host read data, passwords masked to zero
    always_comb begin
        if (HOST_RD_ADDR_I >= mlsc_pkg::PW_LO_ADDR &&
            HOST_RD_ADDR_I <= mlsc_pkg::PW_HI_ADDR) begin
            rd_d = 8'h00;
        end else begin
            rd_d = MEM_RDATA_I; // reads allowed any time
        end
        if (!HOST_RD_I) begin
            rd_d = rd_q;
        end
    end

    // register stage for all state
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESETN_I) begin
            ta_lo_q <= 8'h00;
            ta_hi_q <= 8'h00;
            ofs_q <= 5'h00;
            eofs_q <= 5'h00;
            pf_q <= 1'b0;
            aa_q <= 1'b0;
            copy_q <= 1'b0;
            cp_ofs_q <= 5'h00;
            cp_addr_q <= 16'h0000;
            st_q <= ST_IDLE;
            mip_q <= 1'b0;
            mclr_q <= 1'b0;
            od_q <= 1'b0;
            alarm_q <= 1'b0;
            sec_cnt_q <= 27'h0;
            min_cnt_q <= 6'h00;
            dly_q <= 16'h0000;
            rate_q <= 14'h0000;
            mcnt_q <= 24'h0;
            dcnt_q <= 24'h0;
            req_q <= 1'b0;
            stamp_q <= 1'b0;
            lo_pend_q <= 1'b0;
            lo_byte_q <= 8'h00;
            lo_addr_q <= '0;
            mem_q <= '0;
            rd_q <= 8'h00;
        end else begin
            ta_lo_q <= ta_lo_d;
            ta_hi_q <= ta_hi_d;
            ofs_q <= ofs_d;
            eofs_q <= eofs_d;
            pf_q <= pf_d;
            aa_q <= aa_d;
            copy_q <= copy_d;
            cp_ofs_q <= cp_ofs_d;
            cp_addr_q <= cp_addr_d;
            st_q <= st_d;
            mip_q <= mip_d;
            mclr_q <= mclr_d;
            od_q <= od_d;
            alarm_q <= alarm_d;
            sec_cnt_q <= sec_cnt_d;
            min_cnt_q <= min_cnt_d;
            dly_q <= dly_d;
            rate_q <= rate_d;
            mcnt_q <= mcnt_d;
            dcnt_q <= dcnt_d;
            req_q <= req_d;
            stamp_q <= stamp_d;
            lo_pend_q <= lo_pend_d;
            lo_byte_q <= lo_byte_d;
            lo_addr_q <= lo_addr_d;
            mem_q <= mem_d;
            rd_q <= rd_d;
        end
    end

    // outputs straight from flops; bit 6 fixed zero
    always_ff @(posedge CLK_SYS_I) begin
        TARGET_ADDR_LOW_O <= ta_lo_d;
        TARGET_ADDR_HIGH_O <= ta_hi_d;
        END_STATUS_O <= RESETN_I ? {aa_d, 1'b0, pf_d, eofs_d} : 8'h00;
        HOST_RDATA_O <= RESETN_I ? rd_d : 8'h00;
        MISSION_ACTIVE_O <= RESETN_I & mip_d;
        MEMORY_CLEARED_O <= RESETN_I & mclr_d;
        STAMP_STROBE_O <= RESETN_I & stamp_d;
        SAMPLE_REQ_O <= RESETN_I & req_d;
        SEARCH_RESPOND_O <= RESETN_I & alarm_d & ALARM_EN_I;
        OVERDRIVE_SELECT_O <= RESETN_I & od_d;
        HOST_BLOCKED_O <= RESETN_I & mip_d & mem_d.we &
            (lo_pend_q | SAMPLE_DONE_I);
        MISSION_COUNT_O <= RESETN_I ? mcnt_d : 24'h0;
        DEVICE_COUNT_O <= RESETN_I ? dcnt_d : 24'h0;
        MEM_O <= RESETN_I ? mem_d : '0;
    end

    // checks
    AST_AA_CLEARED_BY_WRITE: assert property (@(posedge CLK_SYS_I)
        disable iff (!RESETN_I) SP_BYTE_VALID_I |=> !aa_q)
        else $error("aa not cleared by scratch write");
    AST_COPY_NEEDS_1F: assert property (@(posedge CLK_SYS_I)
        disable iff (!RESETN_I) $rose(copy_q) |-> $past(eofs_q) == 5'h1f)
        else $error("copy started with short ending offset");
    AST_START_FLAGS: assert property (@(posedge CLK_SYS_I)
        disable iff (!RESETN_I) (st_q == ST_IDLE && st_d == ST_DELAY)
        |=> mip_q && !mclr_q)
        else $error("start did not set flags");
    AST_BIT6_ZERO: assert property (@(posedge CLK_SYS_I)
        disable iff (!RESETN_I) !END_STATUS_O[6])
        else $error("end_status bit 6 set");
    AST_PW_ZERO: assert property (@(posedge CLK_SYS_I)
        disable iff (!RESETN_I) (HOST_RD_I && HOST_RD_ADDR_I == 16'h0228)
        |=> rd_q == 8'h00)
        else $error("password byte leaked");
    AST_ARMED_NO_MCOUNT: assert property (@(posedge CLK_SYS_I)
        disable iff (!RESETN_I) st_q == ST_ARMED |=> $stable(mcnt_q))
        else $error("mission count moved before alarm");
    AST_LOW_BYTE_NEXT: assert property (@(posedge CLK_SYS_I)
        disable iff (!RESETN_I) (st_q == ST_LOG && SAMPLE_DONE_I &&
        CFG_I.entry16) |=> ##1 mem_q.we && mem_q.data == $past(SAMPLE_I[7:0],2))
        else $error("low byte not written next");
    AST_FULL_STOP: assert property (@(posedge CLK_SYS_I)
        disable iff (!RESETN_I) st_q == ST_FULL |=> !$changed(mcnt_q))
        else $error("logging after full without wrap");
    AST_OD_DEFAULT: assert property (@(posedge CLK_SYS_I)
        disable iff (!RESETN_I) (BUS_RESET_I && !OVERDRIVE_SET_I)
        |=> !OVERDRIVE_SELECT_O)
        else $error("overdrive held after bus reset");
    COV_COPY: cover property (@(posedge CLK_SYS_I) $fell(copy_q));
    COV_LOG: cover property (@(posedge CLK_SYS_I)
        st_q == ST_LOG && SAMPLE_DONE_I);
    COV_ALARM_START: cover property (@(posedge CLK_SYS_I) st_q == ST_PRELOG);
endmodule // mlsc_top

/* test/mlsc_host_model.sv */
// mlsc_host_model: behavioural serial bus master issuing decoded commands.
// assumes the bench requests one operation at a time via go_i.
`timescale 1ns/10ps
module mlsc_host_model (
    // clock
    input wire logic clk_i,
    // bench request
    input wire logic go_i,
    input wire mlsc_pkg::mlsc_cmd_e op_i,
    input wire logic [15:0] addr_i,
    input wire logic [5:0] nbytes_i,
    input wire logic partial_i,
    // address registers read back from the device
    input wire logic [7:0] ta_low_i,
    input wire logic [7:0] ta_high_i,
    input wire logic [7:0] es_i,
    // command side toward the device
    output logic done_o,
    output logic strobe_o,
    output mlsc_pkg::mlsc_cmd_e cmd_o,
    output logic [15:0] target_o,
    output logic byte_valid_o,
    output logic [7:0] byte_o,
    output logic partial_o,
    output logic [23:0] auth_o
);
    // strobes move on the falling edge, one cycle wide
    initial begin
        {done_o, strobe_o, byte_valid_o, partial_o} = 4'h0;
        cmd_o = mlsc_pkg::CMD_NONE;
        target_o = 16'h0000;
        byte_o = 8'h00;
        auth_o = 24'h000000;
        forever begin
            @(posedge clk_i);
            if (go_i === 1'b1) begin
                done_o = 1'b0;
                @(negedge clk_i);
                strobe_o = 1'b1;
                cmd_o = op_i;
                target_o = addr_i;
                // auth echoes the bytes as read back
                auth_o = {ta_low_i, ta_high_i, es_i};
                @(negedge clk_i);
                strobe_o = 1'b0;
                target_o = ~target_o;
                auth_o = ~auth_o; // stale values never linger
                if (op_i == mlsc_pkg::CMD_WRITE_SP) begin
                    for (int i = 0; i < nbytes_i; i++) begin
                        byte_valid_o = 1'b1;
                        byte_o = 8'h5a ^ 8'(i);
                        @(negedge clk_i);
                    end
                    byte_valid_o = 1'b0;
                    byte_o = ~byte_o;
                    if (partial_i) begin
                        partial_o = 1'b1;
                        @(negedge clk_i);
                        partial_o = 1'b0;
                    end
                end
                done_o = 1'b1;
            end
        end
    end
endmodule // mlsc_host_model

/* test/test_mlsc_top.sv */
// test_mlsc_top: self-checking bench for mission and scratchpad control.
// assumes the host model drives strobe, command, target, byte and auth inputs; the bench drives clear, stop and speed.
`timescale 1ns/10ps
module test_mlsc_top;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic clear = 1'b0, stop = 1'b0, od_set = 1'b0, bus_rst = 1'b0;
    logic rd = 1'b0, alarm_en = 1'b0, s_done = 1'b0, s_alarm = 1'b0;
    logic [15:0] rd_addr = 16'h0000, s_val = 16'h0000, h_addr = 16'h0000;
    logic [7:0] mem_rdata = 8'ha5;
    mlsc_pkg::mlsc_cfg_s cfg = '0;
    logic h_go = 1'b0, h_part = 1'b0, h_done, strobe, bvalid, bpart;
    mlsc_pkg::mlsc_cmd_e h_op = mlsc_pkg::CMD_NONE, cmd;
    logic [5:0] h_n = 6'h00;
    logic [15:0] tgt;
    logic [7:0] sbyte, ta_lo, ta_hi, es, rdata;
    logic [23:0] auth, mcnt, dcnt;
    logic act, mclr, stamp, sreq, srch, od, blk;
    mlsc_pkg::mlsc_mem_s mem;
    mlsc_pkg::mlsc_mem_s wr_q[$];
    int bad_count = 0, checked = 0, cyc = 0;

    always #5 clk_sys = ~clk_sys;

    mlsc_top uut (.CLK_SYS_I(clk_sys), .RESETN_I(resetn),
        .CMD_STROBE_I(strobe), .CMD_I(cmd), .TARGET_ADDR_I(tgt),
        .SP_BYTE_VALID_I(bvalid), .SP_BYTE_I(sbyte), .SP_PARTIAL_I(bpart),
        .COPY_AUTH_I(auth), .CLEAR_I(clear), .STOP_I(stop),
        .OVERDRIVE_SET_I(od_set), .BUS_RESET_I(bus_rst), .HOST_RD_I(rd),
        .HOST_RD_ADDR_I(rd_addr), .MEM_RDATA_I(mem_rdata), .CFG_I(cfg),
        .ALARM_EN_I(alarm_en), .SAMPLE_DONE_I(s_done),
        .SAMPLE_ALARM_I(s_alarm), .SAMPLE_I(s_val),
        .TARGET_ADDR_LOW_O(ta_lo), .TARGET_ADDR_HIGH_O(ta_hi),
        .END_STATUS_O(es), .HOST_RDATA_O(rdata), .MISSION_ACTIVE_O(act),
        .MEMORY_CLEARED_O(mclr), .STAMP_STROBE_O(stamp),
        .SAMPLE_REQ_O(sreq), .SEARCH_RESPOND_O(srch),
        .OVERDRIVE_SELECT_O(od), .HOST_BLOCKED_O(blk),
        .MISSION_COUNT_O(mcnt), .DEVICE_COUNT_O(dcnt), .MEM_O(mem));

    mlsc_host_model host (.clk_i(clk_sys), .go_i(h_go), .op_i(h_op),
        .addr_i(h_addr), .nbytes_i(h_n), .partial_i(h_part),
        .ta_low_i(ta_lo), .ta_high_i(ta_hi), .es_i(es), .done_o(h_done),
        .strobe_o(strobe), .cmd_o(cmd), .target_o(tgt),
        .byte_valid_o(bvalid), .byte_o(sbyte), .partial_o(bpart),
        .auth_o(auth));

    // collect every memory write, whatever launched it
    always @(negedge clk_sys) begin
        if (resetn && mem.we === 1'b1) begin
            wr_q.push_back(mem);
        end
    end

    // hang guard: the whole run needs a few hundred cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk_v(input string nm, input logic [23:0] e,
                         input logic [23:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_f(input string nm, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask

    // one host operation, waited for under a bound
    task automatic host_op(input mlsc_pkg::mlsc_cmd_e op,
                           input logic [15:0] a, input int n, input logic p);
        int k;
        @(negedge clk_sys);
        h_op = op;
        h_addr = a;
        h_n = 6'(n);
        h_part = p;
        h_go = 1'b1;
        @(negedge clk_sys);
        h_go = 1'b0;
        k = 0;
        while (h_done !== 1'b1 && k < 200) begin
            @(negedge clk_sys);
            k++;
        end
        bad_count += (k == 200);
        repeat (6) @(negedge clk_sys);
    endtask

    task automatic pulse(ref logic s);
        @(negedge clk_sys);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask

    task automatic t_reset();
        chk_v("end_status", 24'h0, es);
        chk_f("overdrive_select", 1'b0, od);
        chk_f("mission_active", 1'b0, act);
        $display("test reset done");
    endtask

    // short write near page end, copy, then a fresh write clears the flag
    task automatic t_copy_ok();
        wr_q.delete();
        host_op(mlsc_pkg::CMD_WRITE_SP, 16'h013c, 4, 1'b0);
        chk_v("ta_low", 24'h3c, ta_lo);
        chk_v("ta_high", 24'h01, ta_hi);
        chk_v("end_status", 24'h1f, es);
        host_op(mlsc_pkg::CMD_COPY_SP, 16'h0000, 0, 1'b0);
        repeat (10) @(negedge clk_sys);
        chk_v("end_status aa", 24'h9f, es);
        chk_v("copy count", 24'h4, 24'(wr_q.size()));
        for (int i = 0; i < 4 && i < wr_q.size(); i++) begin
            chk_v("copy addr", 24'(16'h013c + i), 24'(wr_q[i].addr));
            chk_v("copy data", 24'(8'h5a ^ 8'(i)), 24'(wr_q[i].data));
        end
        host_op(mlsc_pkg::CMD_WRITE_SP, 16'h0200, 32, 1'b0);
        chk_v("end_status rewrite", 24'h1f, es);
        $display("test copy done");
    endtask

    // copies that must be refused: partial byte, short ending offset
    task automatic t_refused();
        logic [15:0] a[2] = '{16'h0100, 16'h0100};
        int n[2] = '{32, 2};
        logic p[2] = '{1'b1, 1'b0};
        logic [7:0] e[2] = '{8'h3f, 8'h01};
        for (int i = 0; i < 2; i++) begin
            host_op(mlsc_pkg::CMD_WRITE_SP, a[i], n[i], p[i]);
            chk_v("end_status", 24'(e[i]), es);
            wr_q.delete();
            host_op(mlsc_pkg::CMD_COPY_SP, 16'h0000, 0, 1'b0);
            repeat (10) @(negedge clk_sys);
            chk_v("refused writes", 24'h0, 24'(wr_q.size()));
            chk_v("aa stays clear", 24'(e[i]), es);
        end
        $display("test refused done");
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        rd = 1'b1;
        rd_addr = a;
        @(negedge clk_sys);
        rd = 1'b0;
        chk_v("host read", 24'(e), 24'(rdata));
    endtask

    // start refused without logging, then a real start and live reads
    task automatic t_mission();
        pulse(clear);
        chk_f("memory_cleared", 1'b1, mclr);
        host_op(mlsc_pkg::CMD_START, 16'h0000, 0, 1'b0);
        chk_f("start ignored", 1'b0, act);
        cfg.logging_enable = 1'b1;
        cfg.high_speed_sampling = 1'b1;
        cfg.sample_rate = mlsc_pkg::RATE_ONE;
        cfg.start_delay = 16'h0000;
        cfg.entry16 = 1'b1;
        host_op(mlsc_pkg::CMD_START, 16'h0000, 0, 1'b0);
        chk_f("mission_active", 1'b1, act);
        chk_f("memory_cleared", 1'b0, mclr);
        rd_chk(16'h0228, 8'h00);
        rd_chk(16'h0237, 8'h00);
        rd_chk(16'h0100, 8'ha5);
        wr_q.delete();
        s_val = 16'h1234;
        alarm_en = 1'b1;
        s_alarm = 1'b1;
        pulse(s_done);
        chk_v("mission count", 24'h1, mcnt);
        chk_v("device count", 24'h1, dcnt);
        chk_v("log high", 24'h12, 24'(wr_q[0].data));
        chk_v("log low addr", 24'h1, 24'(wr_q[1].addr));
        chk_f("search respond", 1'b1, srch);
        pulse(stop);
        chk_f("mission stopped", 1'b0, act);
        $display("test mission done");
    endtask

    task automatic t_speed();
        pulse(od_set);
        chk_f("overdrive_select", 1'b1, od);
        pulse(bus_rst);
        chk_f("overdrive reset", 1'b0, od);
        $display("test speed done");
    endtask

    initial begin
        repeat (16) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (2) @(negedge clk_sys);
        t_reset();
        t_copy_ok();
        t_refused();
        t_mission();
        t_speed();
        wrap_up();
    end
endmodule // test_mlsc_top
